// *** logic/wwdt_prescaler.sv ***
// clock source selection and prescaler of the window watchdog
`include "wwdt_regs.svh"
`default_nettype none

module wwdt_prescaler #(
	parameter int DIV_LONG = `WWDT_DIV_LONG,
	parameter int DIV_SHORT = `WWDT_DIV_SHORT
) (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic wu_clk,
	input wire logic src_wu,
	input wire logic div_short,
	input wire logic restart,
	output logic tick
);

	if (DIV_LONG < 2 || DIV_LONG > 16384 || DIV_SHORT < 2 || DIV_SHORT > DIV_LONG) begin : g_chk
		$error("wwdt_prescaler: divider ratios out of range");
	end

	wwdt_pkg::wwdt_pre_t pre_ff;
	wwdt_pkg::wwdt_pre_t nxt_pre;
	logic src_pulse;
	logic [13:0] limit;

	// ********************************
	// source pulse and divider
	// ********************************
	always_comb begin
		nxt_pre = pre_ff;
		nxt_pre.sync1 = wu_clk;
		nxt_pre.sync2 = pre_ff.sync1;
		nxt_pre.sync3 = pre_ff.sync2;
		nxt_pre.tick = 1'h0;
		src_pulse = src_wu ? (pre_ff.sync2 & ~pre_ff.sync3) : 1'h1;
		limit = div_short ? 14'(DIV_SHORT - 1) : 14'(DIV_LONG - 1);
		if (restart) begin
			nxt_pre.cnt = 14'h0000;
		end else if (src_pulse) begin
			// a ratio change mid-count must not strand the count above the new limit
			if (pre_ff.cnt >= limit) begin
				nxt_pre.cnt = 14'h0000;
				nxt_pre.tick = 1'h1;
			end else begin
				nxt_pre.cnt = 14'(pre_ff.cnt + 14'h0001);
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			pre_ff <= '0;
		end else begin
			pre_ff <= nxt_pre;
		end
	end

	assign tick = pre_ff.tick;

	// ********************************
	// checks
	// ********************************
	property p_div_limit;
		@(posedge clk_sys) disable iff (reset)
		(!restart && src_pulse && pre_ff.cnt == limit) |=> (tick && pre_ff.cnt == 14'h0000);
	endproperty
	a_div_limit: assert property (p_div_limit) else $error("prescaler missed its limit");

endmodule // wwdt_prescaler

`default_nettype wire

// *** logic/wwdt_top.sv ***
// window watchdog with ahb-lite register slave
`include "wwdt_regs.svh"
`default_nettype none

module wwdt_top #(
	parameter int DIV_LONG = `WWDT_DIV_LONG,
	parameter int DIV_SHORT = `WWDT_DIV_SHORT
) (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic wu_clk,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	output logic wdt_reset_req
);

	wwdt_pkg::wwdt_top_t top_ff;
	wwdt_pkg::wwdt_top_t nxt_top;
	logic take;
	logic wr_ctrl;
	logic wr_cmd;
	logic svc;
	logic cmd_off;
	logic cmd_on;
	logic stop;
	logic tick;
	logic restart;

	// ********************************
	// bus decode
	// ********************************
	function automatic logic [31:0] read_word(input logic [7:0] a, input wwdt_pkg::wwdt_top_t s);
		logic [31:0] w;
		w = 32'h00000000;
		case (a)
			`WWDT_ADDR_CTRL: begin
				w[`WWDT_CTRL_SRC_BIT] = s.src_wu;
				w[`WWDT_CTRL_DIV_BIT] = s.div_short;
			end
			`WWDT_ADDR_RELOAD: w[15:0] = s.reload;
			`WWDT_ADDR_WINDOW: w[15:0] = s.window;
			`WWDT_ADDR_STATUS: begin
				w[`WWDT_STAT_RUN_BIT] = (s.fsm == wwdt_pkg::WWDT_RUN);
				w[`WWDT_STAT_OVF_BIT] = s.ovf;
				w[`WWDT_STAT_EARLY_BIT] = s.early;
			end
			`WWDT_ADDR_COUNT: w[15:0] = s.count;
			default: w = 32'h00000000;
		endcase
		return w;
	endfunction

	// every transfer is served as a whole word; hsize is not checked
	assign take = hsel & hready & htrans[1];
	assign wr_ctrl = top_ff.dp_wr && (top_ff.dp_addr == `WWDT_ADDR_CTRL);
	assign wr_cmd = top_ff.dp_wr && (top_ff.dp_addr == `WWDT_ADDR_CMD);
	assign svc = wr_cmd & hwdata[`WWDT_CMD_SERVICE_BIT];
	assign cmd_off = wr_cmd & hwdata[`WWDT_CMD_OFF_BIT];
	assign cmd_on = wr_cmd & hwdata[`WWDT_CMD_ON_BIT];
	// on wins when both commands arrive together, so a write setting both bits cannot silence it
	assign stop = cmd_off & ~cmd_on;
	// a service or a stopped watchdog restarts the prescaler from zero
	assign restart = svc | (top_ff.fsm != wwdt_pkg::WWDT_RUN);

	wwdt_prescaler #(
		.DIV_LONG(DIV_LONG),
		.DIV_SHORT(DIV_SHORT)
	) u_pre (
		.clk_sys(clk_sys),
		.reset(reset),
		.wu_clk(wu_clk),
		.src_wu(top_ff.src_wu),
		.div_short(top_ff.div_short),
		.restart(restart),
		.tick(tick)
	);

	// ********************************
	// next state
	// ********************************
	always_comb begin
		nxt_top = top_ff;
		nxt_top.dp_wr = 1'h0;
		if (take) begin
			nxt_top.dp_wr = hwrite;
			nxt_top.dp_addr = haddr[7:0];
			nxt_top.rdata = hwrite ? 32'h00000000 : read_word(haddr[7:0], top_ff);
		end
		if (wr_ctrl) begin
			nxt_top.src_wu = hwdata[`WWDT_CTRL_SRC_BIT];
			nxt_top.div_short = hwdata[`WWDT_CTRL_DIV_BIT];
		end
		if (top_ff.dp_wr && top_ff.dp_addr == `WWDT_ADDR_RELOAD) begin
			nxt_top.reload = hwdata[15:0];
		end
		if (top_ff.dp_wr && top_ff.dp_addr == `WWDT_ADDR_WINDOW) begin
			nxt_top.window = hwdata[15:0];
		end
		case (top_ff.fsm)
			wwdt_pkg::WWDT_OFF: begin
				if (svc) begin
					nxt_top.count = top_ff.reload;
				end
				if (cmd_on) begin
					nxt_top.fsm = wwdt_pkg::WWDT_RUN;
				end
			end
			wwdt_pkg::WWDT_RUN: begin
				if (stop) begin
					nxt_top.fsm = wwdt_pkg::WWDT_OFF;
				end else if (svc) begin
					if (top_ff.count < top_ff.window) begin
						nxt_top.fsm = wwdt_pkg::WWDT_TRIP;
						nxt_top.early = 1'h1;
					end else begin
						nxt_top.count = top_ff.reload;
					end
				end else if (tick) begin
					if (top_ff.count == `WWDT_COUNT_MAX) begin
						nxt_top.fsm = wwdt_pkg::WWDT_TRIP;
						nxt_top.ovf = 1'h1;
					end else begin
						nxt_top.count = 16'(top_ff.count + 16'h0001);
					end
				end
			end
			// the request holds until the system reset it triggers clears the block
			wwdt_pkg::WWDT_TRIP: nxt_top.fsm = wwdt_pkg::WWDT_TRIP;
			default: nxt_top.fsm = wwdt_pkg::WWDT_OFF;
		endcase
	end

	// ********************************
	// state registers
	// ********************************
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			top_ff.fsm <= wwdt_pkg::WWDT_RUN;
			top_ff.count <= 16'(`WWDT_RST_RELOAD);
			top_ff.reload <= 16'(`WWDT_RST_RELOAD);
			top_ff.window <= `WWDT_RST_WINDOW;
			top_ff.src_wu <= `WWDT_RST_SRC_WU;
			top_ff.div_short <= `WWDT_RST_DIV_SHORT;
			top_ff.ovf <= 1'h0;
			top_ff.early <= 1'h0;
			top_ff.dp_wr <= 1'h0;
			top_ff.dp_addr <= 8'h00;
			top_ff.rdata <= 32'h00000000;
		end else begin
			top_ff <= nxt_top;
		end
	end

	assign hreadyout = 1'h1;
	assign hresp = 1'h0;
	assign hrdata = top_ff.rdata;
	assign wdt_reset_req = (top_ff.fsm == wwdt_pkg::WWDT_TRIP);

	// ********************************
	// checks
	// ********************************
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);

	property p_boot_run;
		$past(reset) |-> (top_ff.fsm == wwdt_pkg::WWDT_RUN && !wdt_reset_req);
	endproperty
	a_boot_run: assert property (p_boot_run) else $error("not running after reset");

	property p_boot_interval;
		$past(reset) |-> (top_ff.reload == 16'hFFFC && top_ff.src_wu && !top_ff.div_short);
	endproperty
	a_boot_interval: assert property (p_boot_interval) else $error("wrong default interval");

	property p_off_cmd;
		(top_ff.fsm == wwdt_pkg::WWDT_RUN && stop) |=> (top_ff.fsm == wwdt_pkg::WWDT_OFF);
	endproperty
	a_off_cmd: assert property (p_off_cmd) else $error("off command ignored");

	property p_on_cmd;
		(top_ff.fsm == wwdt_pkg::WWDT_OFF && cmd_on) |=> (top_ff.fsm == wwdt_pkg::WWDT_RUN);
	endproperty
	a_on_cmd: assert property (p_on_cmd) else $error("on command ignored");

	property p_overflow;
		(top_ff.fsm == wwdt_pkg::WWDT_RUN && !stop && !svc && tick && top_ff.count == 16'hFFFF)
			|=> (wdt_reset_req && top_ff.ovf) [*2];
	endproperty
	a_overflow: assert property (p_overflow) else $error("overflow without request");

	property p_early;
		(top_ff.fsm == wwdt_pkg::WWDT_RUN && !stop && svc && top_ff.count < top_ff.window)
			|=> (wdt_reset_req && top_ff.early && !top_ff.ovf);
	endproperty
	a_early: assert property (p_early) else $error("early service not caught");

	property p_service_reload;
		(top_ff.fsm == wwdt_pkg::WWDT_RUN && !stop && svc && top_ff.count >= top_ff.window)
			|=> (top_ff.count == $past(top_ff.reload) && !wdt_reset_req);
	endproperty
	a_service_reload: assert property (p_service_reload) else $error("service did not reload");

	property p_count_up;
		(top_ff.fsm == wwdt_pkg::WWDT_RUN && !stop && !svc && tick && top_ff.count != 16'hFFFF)
			|=> (top_ff.count == 16'($past(top_ff.count) + 16'h0001));
	endproperty
	a_count_up: assert property (p_count_up) else $error("counter did not step");

	property p_off_hold;
		(top_ff.fsm == wwdt_pkg::WWDT_OFF && !svc && !cmd_on)
			|=> (top_ff.count == $past(top_ff.count) && !wdt_reset_req);
	endproperty
	a_off_hold: assert property (p_off_hold) else $error("disabled watchdog moved");

	property p_no_tick_stay;
		(top_ff.fsm == wwdt_pkg::WWDT_RUN && !stop && !svc && !tick)
			|=> (top_ff.count == $past(top_ff.count) && top_ff.fsm == wwdt_pkg::WWDT_RUN);
	endproperty
	a_no_tick_stay: assert property (p_no_tick_stay) else $error("count moved without tick");

endmodule // wwdt_top

`default_nettype wire

// *** shared/wwdt_pkg.sv ***
// types shared by the window watchdog modules
`default_nettype none

package wwdt_pkg;

	typedef enum logic [1:0] {
		WWDT_OFF,
		WWDT_RUN,
		WWDT_TRIP
	} wwdt_state_t;

	typedef struct packed {
		logic sync1;
		logic sync2;
		logic sync3;
		logic [13:0] cnt;
		logic tick;
	} wwdt_pre_t;

	typedef struct packed {
		wwdt_state_t fsm;
		logic [15:0] count;
		logic [15:0] reload;
		logic [15:0] window;
		logic src_wu;
		logic div_short;
		logic ovf;
		logic early;
		logic dp_wr;
		logic [7:0] dp_addr;
		logic [31:0] rdata;
	} wwdt_top_t;

endpackage

`default_nettype wire

// *** shared/wwdt_regs.svh ***
// register map, field positions, reset values and timing counts of the window watchdog
`ifndef WWDT_REGS_SVH
`define WWDT_REGS_SVH

// ********************************
// register byte offsets
// ********************************
`define WWDT_ADDR_CTRL 8'h00
`define WWDT_ADDR_RELOAD 8'h04
`define WWDT_ADDR_WINDOW 8'h08
`define WWDT_ADDR_CMD 8'h0C
`define WWDT_ADDR_STATUS 8'h10
`define WWDT_ADDR_COUNT 8'h14

// ********************************
// field positions
// ********************************
`define WWDT_CTRL_SRC_BIT 0
`define WWDT_CTRL_DIV_BIT 1
`define WWDT_CMD_SERVICE_BIT 0
`define WWDT_CMD_OFF_BIT 1
`define WWDT_CMD_ON_BIT 2
`define WWDT_STAT_RUN_BIT 0
`define WWDT_STAT_OVF_BIT 1
`define WWDT_STAT_EARLY_BIT 2

// ********************************
// timing and reset values
// ********************************
`define WWDT_DIV_LONG 16384
`define WWDT_DIV_SHORT 256
`define WWDT_WAKEUP_CLOCK_FREQ_HZ 500000
`define WWDT_DEF_INTERVAL_MS 130
`define WWDT_DEF_TICKS \
	((`WWDT_DEF_INTERVAL_MS * (`WWDT_WAKEUP_CLOCK_FREQ_HZ / 1000) + `WWDT_DIV_LONG / 2) / `WWDT_DIV_LONG)
`define WWDT_RST_RELOAD (17'h10000 - 17'(`WWDT_DEF_TICKS))
`define WWDT_RST_SRC_WU 1'h1
`define WWDT_RST_DIV_SHORT 1'h0
`define WWDT_RST_WINDOW 16'h0000
`define WWDT_COUNT_MAX 16'hFFFF

`endif

// *** tb/testbench.sv ***
// self-checking bench of the window watchdog top
`include "wwdt_regs.svh"
`default_nettype none

module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_sys = 1'b0;
	logic reset = 1'b1;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic hreadyout, hresp, wdt_reset_req, wu_clk;
	logic [31:0] hrdata, rd, rd2;
	int n_mismatch = 0;
	int checked = 0;

	always #25 clk_sys = ~clk_sys;

	wwdt_wu_osc #(.HALF_NS(100)) osc (.wu_clk(wu_clk));
	// small dividers keep the run short
	wwdt_top #(.DIV_LONG(16), .DIV_SHORT(4)) dut (.clk_sys(clk_sys), .reset(reset), .wu_clk(wu_clk),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.wdt_reset_req(wdt_reset_req));

	// ********************************
	// shared tasks
	// ********************************
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// entered just after a rising edge, leaves at the edge ending the data phase
	task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		do @(posedge clk_sys); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk_sys); while (hreadyout !== 1'b1);
		r = hrdata;
		chk("hresp", hresp, 32'h0);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] x;
		bus(a, 1'b1, d, x);
		@(posedge clk_sys);
	endtask

	task automatic rdr(input logic [7:0] a, output logic [31:0] r);
		bus(a, 1'b0, 32'h0, r);
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge clk_sys);
	endtask

	task automatic do_reset();
		reset <= 1'b1;
		idle(8);
		reset <= 1'b0;
		@(posedge clk_sys);
	endtask

	task automatic report_and_stop();
		$display("checked %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask

	// ********************************
	// scenarios
	// ********************************
	task automatic t_defaults();
		do_reset();
		rdr(`WWDT_ADDR_CTRL, rd); chk("ctrl", rd, 32'h1);
		rdr(`WWDT_ADDR_RELOAD, rd); chk("reload", rd, 32'hFFFC);
		rdr(`WWDT_ADDR_WINDOW, rd); chk("window", rd, 32'h0);
		rdr(`WWDT_ADDR_STATUS, rd); chk("running", rd & 32'h7, 32'h1);
		rdr(8'h18, rd); chk("unmapped", rd, 32'h0);
		idle(150); chk("no trip early", wdt_reset_req, 1'b0);
		idle(300); chk("wu overflow", wdt_reset_req, 1'b1);
		$display("test defaults done");
	endtask

	// overflow time follows the divider; both runs use the system clock as source
	task automatic t_ovf(input logic [31:0] ctrl, input int e, input int l);
		do_reset();
		wr(`WWDT_ADDR_CTRL, ctrl);
		wr(`WWDT_ADDR_RELOAD, 32'hFFF0);
		bus(`WWDT_ADDR_CMD, 1'b1, 32'h1, rd);
		rdr(`WWDT_ADDR_COUNT, rd); chk("count reload", rd, 32'hFFF0);
		idle(e); chk("before overflow", wdt_reset_req, 1'b0);
		idle(l); chk("overflow", wdt_reset_req, 1'b1);
		rdr(`WWDT_ADDR_STATUS, rd); chk("ovf cause", rd & 32'h6, 32'h2);
		$display("test overflow ctrl %h done", ctrl);
	endtask

	task automatic t_window();
		do_reset();
		wr(`WWDT_ADDR_RELOAD, 32'hFFF0);
		wr(`WWDT_ADDR_WINDOW, 32'hFFF4);
		wr(`WWDT_ADDR_CTRL, 32'h2);
		// reset count is near overflow on the fast divider, so service at once
		wr(`WWDT_ADDR_CMD, 32'h1);
		chk("first service", wdt_reset_req, 1'b0);
		for (int i = 0; i < 5; i++) begin
			idle(40);
			wr(`WWDT_ADDR_CMD, 32'h1);
			chk("valid service", wdt_reset_req, 1'b0);
		end
		wr(`WWDT_ADDR_CMD, 32'h1);
		chk("early service", wdt_reset_req, 1'b1);
		rdr(`WWDT_ADDR_STATUS, rd); chk("early cause", rd & 32'h6, 32'h4);
		$display("test window done");
	endtask

	task automatic t_off_on();
		do_reset();
		wr(`WWDT_ADDR_WINDOW, 32'hFFFF);
		wr(`WWDT_ADDR_CTRL, 32'h2);
		wr(`WWDT_ADDR_CMD, 32'h2);
		rdr(`WWDT_ADDR_STATUS, rd); chk("stopped", rd & 32'h1, 32'h0);
		rdr(`WWDT_ADDR_COUNT, rd);
		idle(80);
		rdr(`WWDT_ADDR_COUNT, rd2); chk("count held", rd2, rd);
		wr(`WWDT_ADDR_CMD, 32'h1);
		chk("no req while off", wdt_reset_req, 1'b0);
		wr(`WWDT_ADDR_CMD, 32'h6);
		rdr(`WWDT_ADDR_STATUS, rd); chk("on wins", rd & 32'h7, 32'h1);
		rdr(`WWDT_ADDR_COUNT, rd);
		idle(8);
		rdr(`WWDT_ADDR_COUNT, rd2); chk("counts up", rd2 > rd, 1'b1);
		$display("test off on done");
	endtask

	initial begin
		idle(1);
		t_defaults();
		t_ovf(32'h2, 40, 120);
		t_ovf(32'h0, 150, 250);
		t_window();
		t_off_on();
		report_and_stop();
	end

	// hang guard, well past the expected run length
	initial begin
		#400000;
		n_mismatch++;
		report_and_stop();
	end
endmodule // testbench

`default_nettype wire

// *** tb/wwdt_wu_osc.sv ***
// free-running wake-up oscillator model feeding the watchdog
`default_nettype none

module wwdt_wu_osc #(
	parameter int HALF_NS = 100
) (
	output logic wu_clk
);
	timeunit 1ns;
	timeprecision 1ns;
	// an oscillator runs free, so no stop between uses
	initial begin
		wu_clk = 1'b0;
		forever #(HALF_NS) wu_clk = ~wu_clk;
	end
endmodule // wwdt_wu_osc

`default_nettype wire
